// [src/timer_match_irq_wakeup.sv]
`timescale 1ns/100ps
`include "timer_match_irq_params.svh"

// Summary of operation
// - Each timer module has separate A-match and P-match flags with own enables.
// - All timer match requests go through the grouped interrupt, no own vector.
// - A timer request exists whenever either of its match flags is set.
// - Vectoring needs global, timer module and group enables all set.
// - With enables set, stack room and a match, call the group vector.
// - Service clears global enable and group flag, not the timer match flags.
// - In sleep or idle, any flag rising from low to high wakes the device.
// - Wake-up ignores all enable bits.
// - A set match flag stays set until cleared by software; service clears only the group flag.
// - Cleared enables hold off service but keep the request flag.
// - Interrupt entry pushes only the program counter.
// - Return-from-interrupt with a non-empty stack pops address and sets the global enable.
// - Plain return pops address and leaves global enable unchanged.
// - Group flag sets whenever any enabled member timer match flag sets.
module timer_match_irq_wakeup
  import timer_match_irq_pkg::*;
(
  // Clock and synchronous reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Timer comparator side, same clock, so no synchroniser
  input wire match_pair_s [`NUM_TIMERS-1:0] match_event,
  input wire match_pair_s [`NUM_TIMERS-1:0] match_enable,
  input wire match_pair_s [`NUM_TIMERS-1:0] match_flag_clear,
  input wire match_pair_s [`NUM_TIMERS-1:0] match_flag_set,
  // Software strobes and levels
  input wire logic global_irq_enable_set,
  input wire logic global_irq_enable_clear,
  input wire logic group_irq_enable,
  input wire logic group_irq_flag_clear,
  input wire logic group_irq_flag_set,
  // Core side: sleep entry, boundaries and pushes
  input wire logic sleep_request,
  input wire core_step_s core_step,
  input wire logic call_push,
  input wire logic [`PC_WIDTH-1:0] current_pc,
  // Request flags and enables back to software
  output match_pair_s [`NUM_TIMERS-1:0] match_flag,
  output logic global_irq_enable,
  output logic group_irq_flag,
  // Vectoring and return path to the core
  output logic stack_full,
  output logic vector_call,
  output logic [`PC_WIDTH-1:0] vector_addr,
  output logic [`PC_WIDTH-1:0] return_addr,
  output logic return_valid,
  // Power state
  output logic low_power,
  output logic wake_up
);

  // ==========================================================
  // Timer match flags, one generate slice per timer module
  // Next flag values, one pair per module
  match_pair_s [`NUM_TIMERS-1:0] next_match_flag;
  // Rise of an enabled flag; feeds the group flag
  logic [`NUM_TIMERS-1:0] member_rise;
  // Enabled and set; a request the core may take
  logic [`NUM_TIMERS-1:0] member_pend;

  // Slices share nothing, so modules never hold each other off
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_TIMERS; gi++) begin : g_timer
      // Set beats clear so a match landing on a clear is kept
      always_comb begin
        next_match_flag[gi] = match_flag[gi];
        // Software clears first so a set below overrides it
        if (match_flag_clear[gi].match_a) begin
          next_match_flag[gi].match_a = 1'b0;
        end
        if (match_flag_clear[gi].match_p) begin
          next_match_flag[gi].match_p = 1'b0;
        end
        // A match or a software preset sets the flag
        if (match_event[gi].match_a || match_flag_set[gi].match_a) begin
          next_match_flag[gi].match_a = 1'b1;
        end
        if (match_event[gi].match_p || match_flag_set[gi].match_p) begin
          next_match_flag[gi].match_p = 1'b1;
        end
      end
      // Rising edge of an enabled member sets the group flag
      assign member_rise[gi] =
        (next_match_flag[gi].match_a & ~match_flag[gi].match_a & match_enable[gi].match_a) |
        (next_match_flag[gi].match_p & ~match_flag[gi].match_p & match_enable[gi].match_p);
      // Pending timer request per module; either flag counts
      assign member_pend[gi] =
        (match_flag[gi].match_a & match_enable[gi].match_a) |
        (match_flag[gi].match_p & match_enable[gi].match_p);
    end
  endgenerate

  // All flags registered together; reset drops every request
  // Enables never touch a flag, so masking keeps requests pending
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < `NUM_TIMERS; i++) begin
        match_flag[i] <= '{match_p: `FLAG_RESET, match_a: `FLAG_RESET};
      end
    end else begin
      match_flag <= next_match_flag;
    end
  end

  // ==========================================================
  // Return stack holding only the program counter
  // Accumulator and status are left to the handler to save
  logic [`PC_WIDTH-1:0] stack_mem [`STACK_DEPTH];
  // Pointer counts used entries; the top bit only marks full
  logic [`STACK_PTR_WIDTH-1:0] stack_ptr;
  logic [`STACK_PTR_WIDTH-1:0] next_stack_ptr;
  logic [`STACK_PTR_WIDTH-2:0] wr_slot;
  logic [`STACK_PTR_WIDTH-2:0] rd_slot;
  // Push and pop strobes for this cycle
  logic do_push;
  logic do_pop;
  logic ret_step;
  // Only the program counter is ever stored
  logic [`PC_WIDTH-1:0] push_value;
  // Popped address and its one-cycle valid
  logic [`PC_WIDTH-1:0] next_return_addr;
  logic next_return_valid;

  // Full at the last entry; vectors wait until a return frees one
  assign stack_full = (stack_ptr == `STACK_PTR_WIDTH'(`STACK_DEPTH));

  // Write at the pointer, read the entry just below it
  assign wr_slot = stack_ptr[`STACK_PTR_WIDTH-2:0];
  assign rd_slot = wr_slot - (`STACK_PTR_WIDTH-1)'(1);

  // Returns only count on an instruction boundary
  assign ret_step = core_step.boundary && (core_step.ret_irq || core_step.ret_plain);

  // ==========================================================
  // Acceptance: all three enables, room on stack, boundary only
  // Any enabled timer request at all
  logic any_pend;
  logic accept;
  assign any_pend = |member_pend;

  // Group flag alone does not vector; a member must be enabled too
  // A return on the same boundary goes first; the vector waits a step
  // Low power does not gate this; the core decides whether it steps
  assign accept = core_step.boundary && global_irq_enable && group_irq_enable &&
                  group_irq_flag && any_pend && !stack_full &&
                  !core_step.ret_irq && !core_step.ret_plain;

  // Combinational pulse so the core can branch at this boundary
  assign vector_call = accept;
  // One fixed address serves every timer source
  assign vector_addr = `GROUP_VECTOR;

  // ==========================================================
  // Group flag and global enable
  logic next_group_irq_flag;
  logic next_global_irq_enable;

  // Next group flag and global enable
  always_comb begin
    // Group flag: cleared by software or service, set by a member rise
    next_group_irq_flag = group_irq_flag;
    if (group_irq_flag_clear || accept) begin
      next_group_irq_flag = 1'b0;
    end
    // A rise in the service cycle re-arms the group flag
    if ((|member_rise) || group_irq_flag_set) begin
      next_group_irq_flag = 1'b1;
    end
    // Global enable: set strobe, then clear or service, then return
    next_global_irq_enable = global_irq_enable;
    if (global_irq_enable_set) begin
      next_global_irq_enable = 1'b1;
    end
    if (global_irq_enable_clear || accept) begin
      next_global_irq_enable = 1'b0;
    end
    // Return-from-interrupt with a non-empty stack wins so a handler can re-arm
    if (core_step.boundary && core_step.ret_irq && stack_ptr != '0) begin
      next_global_irq_enable = 1'b1;
    end
    // Plain return leaves the enable as it stands
  end

  // Group flag and global enable registers
  // Reset leaves interrupts globally disabled
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      group_irq_flag <= `FLAG_RESET;
      global_irq_enable <= `ENABLE_RESET;
    end else begin
      group_irq_flag <= next_group_irq_flag;
      global_irq_enable <= next_global_irq_enable;
    end
  end

  // ==========================================================
  // Stack pointer and popped address; a full stack drops further pushes
  always_comb begin
    // A push in the same cycle as a pop wins; that pop is lost
    do_push = accept || (call_push && !stack_full);
    // A pop on an empty stack is ignored and raises no valid
    do_pop = ret_step && (stack_ptr != '0);
    // Address of the interrupted instruction goes on the stack
    push_value = current_pc;
    next_stack_ptr = stack_ptr;
    next_return_addr = return_addr;
    next_return_valid = 1'b0;
    if (do_push) begin
      next_stack_ptr = stack_ptr + `STACK_PTR_WIDTH'(1);
    end else if (do_pop) begin
      next_stack_ptr = stack_ptr - `STACK_PTR_WIDTH'(1);
      next_return_addr = stack_mem[rd_slot];
      next_return_valid = 1'b1;
    end
  end

  // Pointer and popped address registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stack_ptr <= '0;
      return_addr <= '0;
      return_valid <= 1'b0;
    end else begin
      stack_ptr <= next_stack_ptr;
      return_addr <= next_return_addr;
      return_valid <= next_return_valid;
    end
  end

  // Storage needs no reset; only written entries are ever read
  // A full stack never writes, so no slot is overwritten
  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      stack_mem[wr_slot] <= push_value;
    end
  end

  // ==========================================================
  // Low-power state and wake-up on any rising flag, enables ignored
  // Rise of any flag, the group flag included
  logic any_flag_rise;
  power_state_e power_state;
  power_state_e next_power_state;
  logic next_wake_up;

  // Next against current, so a rise counts in the cycle it happens;
  // a flag preset before sleep cannot rise again and stays quiet
  always_comb begin
    any_flag_rise = (!group_irq_flag && next_group_irq_flag);
    for (int i = 0; i < `NUM_TIMERS; i++) begin
      any_flag_rise = any_flag_rise |
        (next_match_flag[i].match_a & ~match_flag[i].match_a) |
        (next_match_flag[i].match_p & ~match_flag[i].match_p);
    end
  end

  // Sleep is left only on a rise; no enable plays a part
  always_comb begin
    next_power_state = power_state;
    next_wake_up = 1'b0;
    case (power_state)
      RUNNING: begin
        // Sleep request is taken in any cycle
        if (sleep_request) begin
          next_power_state = LOW_POWER;
        end
      end
      LOW_POWER: begin
        // Wake pulse lasts one cycle; the state leaves at once
        if (any_flag_rise) begin
          next_power_state = RUNNING;
          next_wake_up = 1'b1;
        end
      end
      default: begin
        // Unused encoding falls back to running
        next_power_state = RUNNING;
      end
    endcase
  end

  // State and one-cycle wake pulse registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      power_state <= RUNNING;
      wake_up <= 1'b0;
    end else begin
      power_state <= next_power_state;
      wake_up <= next_wake_up;
    end
  end

  // Straight from the state register, so no decode glitches
  assign low_power = (power_state == LOW_POWER);

endmodule

// [pkg/timer_match_irq_params.svh]
`ifndef TIMER_MATCH_IRQ_PARAMS_SVH
`define TIMER_MATCH_IRQ_PARAMS_SVH

// ==========================================================
// Sizes and reset values
`define NUM_TIMERS 4
`define PC_WIDTH 13
`define STACK_DEPTH 8
`define STACK_PTR_WIDTH 4
`define GROUP_VECTOR 13'h0010
`define FLAG_RESET 1'b0
`define ENABLE_RESET 1'b0

`endif

// [pkg/timer_match_irq_pkg.sv]
`include "timer_match_irq_params.svh"

package timer_match_irq_pkg;

  // ==========================================================
  // Per timer module match enables or events
  typedef struct packed {
    logic match_p;
    logic match_a;
  } match_pair_s;

  // ==========================================================
  // Core instruction-boundary signals
  typedef struct packed {
    logic boundary;
    logic ret_irq;
    logic ret_plain;
  } core_step_s;

  typedef enum logic [1:0] {
    RUNNING,
    LOW_POWER
  } power_state_e;

endpackage

// [test/irq_chk.sv]
`timescale 1ns/100ps
`include "timer_match_irq_params.svh"
// ==========================================================
// Port-level checks of the grouped match interrupt
module irq_chk
  import timer_match_irq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire match_pair_s [`NUM_TIMERS-1:0] match_event,
  input wire match_pair_s [`NUM_TIMERS-1:0] match_flag_clear,
  input wire match_pair_s [`NUM_TIMERS-1:0] match_flag_set,
  input wire logic global_irq_enable_set,
  input wire logic global_irq_enable_clear,
  input wire logic group_irq_enable,
  input wire logic group_irq_flag_set,
  input wire core_step_s core_step,
  input wire match_pair_s [`NUM_TIMERS-1:0] match_flag,
  input wire logic global_irq_enable,
  input wire logic group_irq_flag,
  input wire logic stack_full,
  input wire logic vector_call,
  input wire logic [`PC_WIDTH-1:0] vector_addr,
  input wire logic low_power,
  input wire logic wake_up
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_vec_gated: assert property (vector_call |-> global_irq_enable && group_irq_enable
    && group_irq_flag && !stack_full) else $error("vector without enables");
  a_vec_boundary: assert property (vector_call |-> core_step.boundary
    && !core_step.ret_irq) else $error("vector off boundary");
  a_vec_addr: assert property (vector_call |-> vector_addr == `GROUP_VECTOR)
    else $error("wrong vector");
  a_svc_clears: assert property (vector_call && !group_irq_flag_set && match_event == '0
    && match_flag_set == '0 |=> !global_irq_enable && !group_irq_flag) else $error("no clear");
  a_svc_keeps: assert property (vector_call && match_flag_clear == '0
    |=> (match_flag & $past(match_flag)) == $past(match_flag)) else $error("flag lost");
  a_flag_capture: assert property (1'b1
    |=> (match_flag & $past(match_event)) == $past(match_event)) else $error("event lost");
  a_flag_hold: assert property (1'b1 |=> ((match_flag | $past(match_flag_clear))
    & $past(match_flag)) == $past(match_flag)) else $error("flag dropped");
  a_return_from_irq_instr_sets: assert property (core_step.boundary && core_step.ret_irq
    |=> global_irq_enable) else $error("enable not restored");
  a_plain_keeps: assert property (core_step.boundary && core_step.ret_plain
    && !core_step.ret_irq && !global_irq_enable_set && !global_irq_enable_clear
    |=> $stable(global_irq_enable)) else $error("enable changed");
  a_wake_rise: assert property ($past(low_power)
    && (match_flag & ~$past(match_flag)) != '0 |-> wake_up) else $error("no wake");
endmodule
bind timer_match_irq_wakeup irq_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .match_event(match_event), .match_flag_clear(match_flag_clear),
  .match_flag_set(match_flag_set), .global_irq_enable_set(global_irq_enable_set),
  .global_irq_enable_clear(global_irq_enable_clear), .group_irq_enable(group_irq_enable),
  .group_irq_flag_set(group_irq_flag_set), .core_step(core_step), .match_flag(match_flag),
  .global_irq_enable(global_irq_enable), .group_irq_flag(group_irq_flag),
  .stack_full(stack_full), .vector_call(vector_call), .vector_addr(vector_addr),
  .low_power(low_power), .wake_up(wake_up));

// [test/core_model.sv]
`timescale 1ns/100ps
`include "timer_match_irq_params.svh"
// ==========================================================
// Core stand-in: boundaries, returns and a moving PC
module core_model
  import timer_match_irq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic step,
  input wire logic [1:0] ret_kind,
  output core_step_s core_step,
  output logic [`PC_WIDTH-1:0] current_pc
);
  logic [`PC_WIDTH-1:0] next_pc;
  // Returns only ride on a boundary; handlers never call, so no push
  always_comb begin
    core_step = '{step, step && ret_kind == 2'h1, step && ret_kind == 2'h2};
    next_pc = step ? current_pc + 13'h0007 : current_pc;
  end
  always_ff @(posedge clk_sys) begin
    current_pc <= sys_rst ? 13'h0100 : next_pc;
  end
endmodule

// [test/tb.sv]
`timescale 1ns/100ps
`include "timer_match_irq_params.svh"
// ==========================================================
// Bench for the grouped timer match interrupt
module tb;
  import timer_match_irq_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  match_pair_s [`NUM_TIMERS-1:0] ev = '0, en = '0, clr = '0, pset = '0, flag;
  logic gset = 1'b0, genb = 1'b0, sleep = 1'b0, step = 1'b0, push = 1'b0;
  logic gie, gflag, vcall, rvalid, lp, wake, got, full;
  logic [1:0] rk = 2'h0;
  logic [`PC_WIDTH-1:0] pc, vaddr, raddr, pc_exp;
  logic [31:0] lf = 32'hc0bf05ac;
  core_step_s cs;
  int bad_count = 0;
  int total_checks = 0;
  int k;
  timer_match_irq_wakeup DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .match_event(ev),
    .match_enable(en), .match_flag_clear(clr), .match_flag_set(pset),
    .global_irq_enable_set(gset), .global_irq_enable_clear(1'b0), .group_irq_enable(genb),
    .group_irq_flag_clear(1'b0), .group_irq_flag_set(1'b0), .sleep_request(sleep),
    .core_step(cs), .call_push(push), .current_pc(pc), .match_flag(flag),
    .global_irq_enable(gie), .group_irq_flag(gflag), .stack_full(full), .vector_call(vcall),
    .vector_addr(vaddr), .return_addr(raddr), .return_valid(rvalid), .low_power(lp),
    .wake_up(wake));
  core_model core (.clk_sys(clk_sys), .sys_rst(sys_rst), .step(step), .ret_kind(rk),
    .core_step(cs), .current_pc(pc));
  // Free-running system clock
  always #25 clk_sys = ~clk_sys;
  // ==========================================================
  // Helpers
  function automatic logic [7:0] one_hot(input int n);
    return 8'h01 << n;
  endfunction
  task automatic tick;
    @(posedge clk_sys);
    #5 lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Bounded look for a wake pulse; it stands one cycle from the flag edge
  task automatic wait_wake(output logic woke);
    woke = 1'b0;
    repeat (4) begin
      if (wake === 1'b1) woke = 1'b1;
      tick;
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    #5 sys_rst = 1'b0;
    // Each source twice, both return kinds, random extra enables
    for (int r = 0; r < 16; r++) begin
      k = r % 8;
      en = lf[7:0] | one_hot(k);
      genb = 1'b1;
      gset = 1'b1;
      tick;
      gset = 1'b0;
      ev = one_hot(k);
      tick;
      ev = '0;
      check("match_flag", flag, one_hot(k));
      check("group_flag", gflag, 1'b1);
      check("early_vector", vcall, 1'b0);
      step = 1'b1;
      #1 pc_exp = pc;
      check("vector_call", vcall, 1'b1);
      check("vector_addr", vaddr, `GROUP_VECTOR);
      tick;
      step = 1'b0;
      check("gie_after", {gie, gflag}, 2'b00);
      check("flag_after", flag, one_hot(k));
      clr = one_hot(k);
      tick;
      clr = '0;
      step = 1'b1;
      rk = ((k + r / 8) % 2 == 1) ? 2'h2 : 2'h1;
      tick;
      step = 1'b0;
      check("return", {rvalid, raddr}, {1'b1, pc_exp});
      check("gie_ret", gie, rk == 2'h1);
      rk = 2'h0;
    end
    // Disabled source: held pending, never vectored
    k = lf % 8;
    en = ~one_hot(k);
    gset = 1'b1;
    ev = one_hot(k);
    tick;
    {gset, ev} = '0;
    step = 1'b1;
    #1 check("blocked", vcall, 1'b0);
    tick;
    step = 1'b0;
    check("pending", flag, one_hot(k));
    // Sleep: disabled source wakes, preset source does not
    en = '0;
    clr = one_hot(k);
    sleep = 1'b1;
    tick;
    {clr, sleep} = '0;
    check("low_power", lp, 1'b1);
    ev = one_hot((k + 3) % 8);
    tick;
    ev = '0;
    wait_wake(got);
    check("wake", got, 1'b1);
    pset = one_hot(k);
    sleep = 1'b1;
    tick;
    {pset, sleep} = '0;
    ev = one_hot(k);
    tick;
    ev = '0;
    wait_wake(got);
    check("no_wake", got, 1'b0);
    check("asleep", lp, 1'b1);
    // Full stack holds off a vector even with every enable set
    push = 1'b1;
    repeat (7) tick;
    check("not_full", full, 1'b0);
    tick;
    push = 1'b0;
    check("stack_full", full, 1'b1);
    en = '1;
    ev = one_hot((k + 5) % 8);
    tick;
    ev = '0;
    check("woken", {lp, gflag}, 2'b01);
    step = 1'b1;
    #1 check("full_block", vcall, 1'b0);
    tick;
    step = 1'b0;
    print_verdict;
  end
endmodule
